// ==== rtl/shc_map.svh ====
// Constants of the sample-and-hold channel control block.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH

// System clock period in nanoseconds.
`define SHC_CLK_NS 10
// Channel counts and widths.
`define SHC_NCHAN 32
`define SHC_NCODES 33
`define SHC_CODE_W 14
`define SHC_OFFSET_IDX 6'h20
// Stored code value after any reset.
`define SHC_CODE_RST 14'h0000
// Serial frame lengths and the last bit index of each.
`define SHC_WR_LAST (5'h0a - 5'h01)
`define SHC_RD_LAST (5'h0e - 5'h01)
`define SHC_TEST_LAST (5'h18 - 5'h01)
// Single channel acquisition, longest, in microseconds.
`define SHC_ACQ_US 16
`define SHC_ACQ_CYC ((`SHC_ACQ_US * 1000) / `SHC_CLK_NS)
// All-channel acquisition, typical, in microseconds.
`define SHC_ALL_US 45
`define SHC_ALL_ACQ_CYC ((`SHC_ALL_US * 1000) / `SHC_CLK_NS)
// Reset pulse window on the defer/reset pin, in nanoseconds.
`define SHC_RST_MIN_NS 90
`define SHC_RST_MAX_NS 200
`define SHC_RST_MIN_CYC ((`SHC_RST_MIN_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_RST_MAX_CYC (`SHC_RST_MAX_NS / `SHC_CLK_NS)
// Cycles that a reset request to the link side is stretched.
`define SHC_LRST_HOLD 6'h20

`endif

// ==== rtl/shc_pkg.sv ====
// Types of the sample-and-hold channel control block.
// Assumes nothing of its surroundings.
package shc_pkg;
  // Operating modes carried in the two leading command bits.
  typedef enum logic [1:0] {
    SHC_MODE_HOLD = 2'h0,
    SHC_MODE_TEST = 2'h1,
    SHC_MODE_ACQ_RB = 2'h2,
    SHC_MODE_RB = 2'h3
  } shc_mode_t;
  // Ten-bit command word, first-sent bit at the top.
  typedef struct packed {
    shc_mode_t mode;
    logic all_chan;
    logic offset_sel;
    logic test;
    logic [4:0] channel_address;
  } shc_cmd_t;
  // Parallel port command pins.
  typedef struct packed {
    logic all_chan;
    logic offset_sel;
    logic [4:0] channel_address;
  } shc_par_t;
  // Acquisition sequencer states.
  typedef enum logic [1:0] {
    SHC_ACQ_IDLE = 2'h0,
    SHC_ACQ_RUN = 2'h1,
    SHC_ACQ_DEFER = 2'h2
  } shc_acq_t;
  // Serial frame phases.
  typedef enum logic [1:0] {
    SHC_PH_IDLE = 2'h0,
    SHC_PH_WRITE = 2'h1,
    SHC_PH_READ = 2'h3,
    SHC_PH_CLEAR = 2'h2
  } shc_phase_t;
endpackage

// ==== rtl/shc_top.sv ====
// Channel control of a 32-channel sample-and-hold converter.
// Assumes sync_n and din are launched by the host on sclk, and that the
// converter result conv_code is valid on clk whenever it is stored.
`timescale 1ns/1ps
`include "shc_map.svh"

// Function
// - Track high at addressing starts acquisition at once.
// - Track low routes input, waits for track rise.
// - Busy output stays low throughout acquisition.
// - Busy rising hands output over to stored code.
// - First two serial bits select operating mode.
// - Mode 01 enters test, cleared by 24-clock write.
// - Acquire then read back fourteen bits, input ignored.
// - Readback-only mode shifts stored code, no acquisition.
// - Strap high picks serial port, low parallel.
// - Serial output changes on rising clock edges.
// - All-channel bit acquires all 32 channels together, not the offset channel.
// - Offset select addresses offset channel, ignores address.
// - Five-bit address selects one of 32 channels.
// - Frame-select fall clears counter, starts shifting.
// - Mid-frame select edges ignored, clock ignored after.
// - Output driven from first rise until 14th fall.
// - Serial input sampled on falling clock edges of write frames.
// - Parallel address latched on rising write strobe.
// - Parallel offset and all pins act like bits.
// - Low pulse 90 to 200 ns resets everything.
// - Reset clears every stored channel code.
module shc_top #(
  parameter int ALL_ACQ_CYCLES = `SHC_ALL_ACQ_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic port_select,
  input wire logic track_reset_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic sdo_o,
  output logic sdo_oe_n,
  input wire logic wr_n,
  input wire logic [4:0] channel_address,
  input wire logic par_offset_sel,
  input wire logic par_all_chan,
  input wire logic [13:0] conv_code,
  output logic busy_n,
  output logic [32:0] follow_input,
  output logic [31:0][13:0] readback_code,
  output logic [13:0] offset_channel_output
);

  // Decodes whether channel idx belongs to a target selection.
  function automatic logic chan_hit(input logic [5:0] tgt,
                                    input logic all, input int idx);
    chan_hit = all ? (idx < `SHC_NCHAN) : (tgt == 6'(idx));
  endfunction

  // Two-flop synchronisers of the pins seen by the system clock.
  logic [1:0] trk_s_q, ps_s_q, wr_s_q, cs_s_q;
  shc_pkg::shc_par_t par_m_q, par_s_q;
  // Synchronised levels and their previous values.
  logic trk_prev_q, wr_prev_q;
  logic trk_lvl, ps_lvl, wr_lvl, cs_lvl;
  // Count of system cycles that the defer/reset pin has been low.
  logic [4:0] low_cnt_q;
  // One-cycle reset request from a valid reset pulse.
  logic soft_rst_q;
  // Reset of all channel state.
  logic rst;
  // Stretch counter that keeps the link side in reset long enough.
  logic [5:0] lrst_cnt_q;
  logic lrst_req;

  // Pin synchronisers; each first stage feeds only its second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      trk_s_q <= 2'h3;
      ps_s_q <= 2'h0;
      wr_s_q <= 2'h3;
      cs_s_q <= 2'h3;
      par_m_q <= '0;
      par_s_q <= '0;
    end else begin
      trk_s_q <= {trk_s_q[0], track_reset_n};
      ps_s_q <= {ps_s_q[0], port_select};
      wr_s_q <= {wr_s_q[0], wr_n};
      cs_s_q <= {cs_s_q[0], sync_n};
      par_m_q <= {par_all_chan, par_offset_sel, channel_address};
      par_s_q <= par_m_q;
    end
  end

  assign trk_lvl = trk_s_q[1];
  assign ps_lvl = ps_s_q[1];
  assign wr_lvl = wr_s_q[1];
  assign cs_lvl = cs_s_q[1];

  // Pulse-width classification of the shared defer/reset pin.
  logic trk_rise, pulse_ok, defer_low, defer_rise;
  assign trk_rise = trk_lvl & ~trk_prev_q;
  assign pulse_ok = trk_rise &&
                    (low_cnt_q >= 5'(`SHC_RST_MIN_CYC)) &&
                    (low_cnt_q <= 5'(`SHC_RST_MAX_CYC));
  // A low longer than the reset window acts as defer-acquire.
  assign defer_low = ~trk_lvl && (low_cnt_q > 5'(`SHC_RST_MAX_CYC));
  assign defer_rise = trk_rise && (low_cnt_q > 5'(`SHC_RST_MAX_CYC));

  // Low-time counter, saturating just past the reset window.
  always_ff @(posedge clk) begin
    if (reset) begin
      low_cnt_q <= 5'h00;
      trk_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      soft_rst_q <= 1'b0;
    end else begin
      trk_prev_q <= trk_lvl;
      wr_prev_q <= wr_lvl;
      soft_rst_q <= pulse_ok;
      if (trk_lvl) begin
        low_cnt_q <= 5'h00;
      end else if (low_cnt_q <= 5'(`SHC_RST_MAX_CYC)) begin
        low_cnt_q <= low_cnt_q + 5'h01;
      end
    end
  end

  assign rst = reset | soft_rst_q;
  assign lrst_req = rst | (lrst_cnt_q != 6'h00);

  // Holds the link reset request for several link clock periods.
  always_ff @(posedge clk) begin
    if (rst) begin
      lrst_cnt_q <= `SHC_LRST_HOLD;
    end else if (lrst_cnt_q != 6'h00) begin
      lrst_cnt_q <= lrst_cnt_q - 6'h01;
    end
  end

  // Link side: command word and event toggle handed to clk.
  shc_pkg::shc_cmd_t cmd_word_q;
  logic cmd_tgl_q;
  // Readback word handed from clk to the link side.
  logic [13:0] rb_word_q;
  logic rd_arm_q;

  // Command arrival from either port.
  logic [2:0] tgl_s_q;
  logic ser_take, par_take, take;
  shc_pkg::shc_cmd_t cmd_in;
  logic [5:0] tgt_d;
  logic acquiring;

  // Toggle synchroniser of the serial command event.
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s_q <= 3'h0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], cmd_tgl_q};
    end
  end

  assign ser_take = (tgl_s_q[2] ^ tgl_s_q[1]) & ps_lvl;
  assign par_take = wr_lvl & ~wr_prev_q & ~cs_lvl & ~ps_lvl;
  // Parallel pins map onto the same fields as the serial bits.
  assign cmd_in = ser_take ? cmd_word_q :
                  {shc_pkg::SHC_MODE_HOLD, par_s_q.all_chan,
                   par_s_q.offset_sel, 1'b0,
                   par_s_q.channel_address};
  assign tgt_d = cmd_in.offset_sel ? `SHC_OFFSET_IDX :
                 {1'b0, cmd_in.channel_address};
  assign acquiring = (cmd_in.mode == shc_pkg::SHC_MODE_HOLD) ||
                     (cmd_in.mode == shc_pkg::SHC_MODE_ACQ_RB);

  // Acquisition sequencer.
  shc_pkg::shc_acq_t acq_q, acq_d;
  logic [12:0] tmr_q, lim;
  logic [5:0] tgt_q;
  logic all_q, rb_mode_q, busy_n_q, start_acq, acq_done;
  logic [13:0] code_q [0:32];
  logic follow_q [0:32];

  // Commands are refused while an acquisition runs.
  assign take = (ser_take | par_take) & (acq_q != shc_pkg::SHC_ACQ_RUN);
  assign start_acq = take & acquiring;
  assign lim = all_q ? 13'(ALL_ACQ_CYCLES) : 13'(`SHC_ACQ_CYC);
  assign acq_done = (acq_q == shc_pkg::SHC_ACQ_RUN) &&
                    (tmr_q == lim - 13'h0001);

  // Next state of the sequencer.
  always_comb begin
    acq_d = acq_q;
    case (acq_q)
      shc_pkg::SHC_ACQ_IDLE, shc_pkg::SHC_ACQ_DEFER: begin
        if (start_acq) begin
          acq_d = defer_low ? shc_pkg::SHC_ACQ_DEFER :
                  shc_pkg::SHC_ACQ_RUN;
        end else if (acq_q == shc_pkg::SHC_ACQ_DEFER && defer_rise) begin
          acq_d = shc_pkg::SHC_ACQ_RUN;
        end
      end
      shc_pkg::SHC_ACQ_RUN: begin
        if (acq_done) begin
          acq_d = shc_pkg::SHC_ACQ_IDLE;
        end
      end
      default: begin
        acq_d = shc_pkg::SHC_ACQ_IDLE;
      end
    endcase
  end

  // Sequencer registers, timer and busy output.
  always_ff @(posedge clk) begin
    if (rst) begin
      acq_q <= shc_pkg::SHC_ACQ_IDLE;
      busy_n_q <= 1'b1;
      tmr_q <= 13'h0000;
    end else begin
      acq_q <= acq_d;
      busy_n_q <= (acq_d != shc_pkg::SHC_ACQ_RUN);
      tmr_q <= (acq_q == shc_pkg::SHC_ACQ_RUN) ? tmr_q + 13'h0001 :
               13'h0000;
    end
  end

  // Target latch and readback word.
  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_q <= 6'h00;
      all_q <= 1'b0;
      rb_mode_q <= 1'b0;
      rb_word_q <= `SHC_CODE_RST;
    end else if (start_acq) begin
      tgt_q <= tgt_d;
      all_q <= cmd_in.all_chan;
      rb_mode_q <= (cmd_in.mode == shc_pkg::SHC_MODE_ACQ_RB);
    end else if (take) begin
      rb_word_q <= code_q[tgt_d];
    end else if (acq_done && rb_mode_q) begin
      rb_word_q <= conv_code;
    end
  end

  // Per-channel code storage and output buffer source.
  for (genvar i = 0; i < `SHC_NCODES; i++) begin : g_chan
    logic hit_new, hit_cur;
    assign hit_new = chan_hit(tgt_d, cmd_in.all_chan, i);
    assign hit_cur = chan_hit(tgt_q, all_q, i);
    always_ff @(posedge clk) begin
      if (rst) begin
        code_q[i] <= `SHC_CODE_RST;
        follow_q[i] <= 1'b0;
      end else if (acq_done && hit_cur) begin
        code_q[i] <= conv_code;
        follow_q[i] <= 1'b0;
      end else if (start_acq && hit_new) begin
        follow_q[i] <= 1'b1;
      end
    end
    assign follow_input[i] = follow_q[i];
  end

  for (genvar i = 0; i < `SHC_NCHAN; i++) begin : g_out
    assign readback_code[i] = code_q[i];
  end
  assign offset_channel_output = code_q[32];
  assign busy_n = busy_n_q;

  // Link domain on the host's shift clock.
  logic lrst_m_q, lrst_q, psl_m_q, psl_q;
  shc_pkg::shc_phase_t ph_q;
  logic [4:0] cnt_q;
  logic [8:0] sh_q;
  logic sync_prev_q, rd_end_q, test_q, start;
  logic sync_hi_q, rd_on_q, dout_q;
  logic [13:0] rd_sh_q;
  shc_pkg::shc_cmd_t word;

  // Reset and strap synchronisers on the link clock.
  always_ff @(posedge sclk) begin
    lrst_m_q <= lrst_req;
    lrst_q <= lrst_m_q;
    psl_m_q <= port_select;
    psl_q <= psl_m_q;
  end

  // A frame starts only on a select fall seen while idle.
  assign start = sync_prev_q & ~sync_n & psl_q &
                 (ph_q == shc_pkg::SHC_PH_IDLE);
  assign word = {sh_q, din};

  // Falling-edge frame engine: samples input and counts bits.
  always_ff @(negedge sclk) begin
    if (lrst_q) begin
      ph_q <= shc_pkg::SHC_PH_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 9'h000;
      sync_prev_q <= 1'b1;
      cmd_word_q <= '0;
      cmd_tgl_q <= 1'b0;
      rd_arm_q <= 1'b0;
      rd_end_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_n;
      cnt_q <= cnt_q + 5'h01;
      if (start) begin
        cnt_q <= 5'h01;
        sh_q <= {8'h00, din};
        ph_q <= test_q ? shc_pkg::SHC_PH_CLEAR :
                rd_arm_q ? shc_pkg::SHC_PH_READ :
                shc_pkg::SHC_PH_WRITE;
      end else begin
        case (ph_q)
          shc_pkg::SHC_PH_WRITE: begin
            sh_q <= word[8:0];
            if (cnt_q == `SHC_WR_LAST) begin
              ph_q <= shc_pkg::SHC_PH_IDLE;
              cmd_word_q <= word;
              if (word.mode == shc_pkg::SHC_MODE_TEST) begin
                test_q <= 1'b1;
              end else begin
                cmd_tgl_q <= ~cmd_tgl_q;
                rd_arm_q <= word.mode[1];
                rd_end_q <= 1'b0;
              end
            end
          end
          shc_pkg::SHC_PH_READ: begin
            if (cnt_q == `SHC_RD_LAST) begin
              ph_q <= shc_pkg::SHC_PH_IDLE;
              rd_arm_q <= 1'b0;
              rd_end_q <= 1'b1;
            end
          end
          shc_pkg::SHC_PH_CLEAR: begin
            if (cnt_q == `SHC_TEST_LAST) begin
              ph_q <= shc_pkg::SHC_PH_IDLE;
              test_q <= 1'b0;
            end
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
    end
  end

  // Rising-edge output shifter; the word was settled by the host wait.
  always_ff @(posedge sclk) begin
    if (lrst_q) begin
      sync_hi_q <= 1'b1;
      rd_on_q <= 1'b0;
      dout_q <= 1'b0;
      rd_sh_q <= 14'h0000;
    end else begin
      sync_hi_q <= sync_n;
      if (!rd_arm_q) begin
        rd_on_q <= 1'b0;
      end else if (!rd_on_q && sync_hi_q && !sync_n && psl_q) begin
        rd_on_q <= 1'b1;
        dout_q <= rb_word_q[13];
        rd_sh_q <= {rb_word_q[12:0], 1'b0};
      end else if (rd_on_q) begin
        dout_q <= rd_sh_q[13];
        rd_sh_q <= {rd_sh_q[12:0], 1'b0};
      end
    end
  end

  assign sdo_o = dout_q;
  assign sdo_oe_n = ~(rd_on_q & ~rd_end_q);

  // Helper: cycles that busy has been low.
  localparam int A_ACQ = `SHC_ACQ_CYC;
  logic [12:0] busy_len_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_len_q <= 13'h0000;
    end else begin
      busy_len_q <= busy_n_q ? 13'h0000 : busy_len_q + 13'h0001;
    end
  end

  a_acq_length: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_n_q) && !all_q |-> busy_len_q == 13'(A_ACQ))
    else $error("single acquisition length wrong");
  a_all_length: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_n_q) && all_q |-> busy_len_q == 13'(ALL_ACQ_CYCLES))
    else $error("all-channel acquisition length wrong");
  a_immed_acq: assert property (@(posedge clk) disable iff (rst)
    start_acq && !defer_low |=> !busy_n_q ##1 !busy_n_q)
    else $error("acquisition did not start at once");
  a_defer_route: assert property (@(posedge clk) disable iff (rst)
    start_acq && defer_low && !cmd_in.all_chan |=>
    follow_q[tgt_q] && busy_n_q)
    else $error("deferred channel not routed to input");
  a_defer_wait: assert property (@(posedge clk) disable iff (rst)
    acq_q == shc_pkg::SHC_ACQ_DEFER && !defer_rise && !start_acq
    |=> busy_n_q)
    else $error("deferred acquisition started early");
  a_hand_over: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_n_q) && !all_q |-> !follow_q[tgt_q] &&
    code_q[tgt_q] == $past(conv_code))
    else $error("output not handed to stored code");
  a_rb_noacq: assert property (@(posedge clk) disable iff (rst)
    take && cmd_in.mode == shc_pkg::SHC_MODE_RB |=> busy_n_q[*2])
    else $error("readback-only mode acquired");
  a_offset_sel: assert property (@(posedge clk) disable iff (rst)
    start_acq && cmd_in.offset_sel |=> tgt_q == `SHC_OFFSET_IDX)
    else $error("offset channel not addressed");
  a_reset_zero: assert property (@(posedge clk) disable iff (reset)
    soft_rst_q |=> code_q[0] == 14'h0000 && code_q[32] == 14'h0000
    && busy_n_q)
    else $error("reset pulse did not clear codes");
  a_sdo_release: assert property (@(negedge sclk)
    disable iff (lrst_q)
    ph_q == shc_pkg::SHC_PH_READ && cnt_q == `SHC_RD_LAST
    && !start |=> sdo_oe_n)
    else $error("serial output not released after 14th clock");

  c_defer: cover property (@(posedge clk) disable iff (rst)
    acq_q == shc_pkg::SHC_ACQ_DEFER ##1 acq_q == shc_pkg::SHC_ACQ_RUN);
  c_all: cover property (@(posedge clk) disable iff (rst)
    $rose(busy_n_q) && all_q);
  c_soft_rst: cover property (@(posedge clk) disable iff (reset)
    soft_rst_q);
  c_readback: cover property (@(negedge sclk) disable iff (lrst_q)
    ph_q == shc_pkg::SHC_PH_READ && cnt_q == `SHC_RD_LAST);

endmodule

// ==== bench/shc_host_model.sv ====
// Host serial port model: shift clock, frame select and data lines.
// Assumes the block samples on falling and drives on rising clock edges.
`timescale 1ns/1ps
module shc_host_model (
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic sdo_o,
  input wire logic sdo_oe_n
);
  // Idle: clock still, select high, data line parked.
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // One 64 ns clock; select and data move well clear of both edges.
  task automatic tick(input logic s, input logic b);
    #8 sync_n = s;
    din = b;
    #24 sclk = 1'b1;
    #32 sclk = 1'b0;
  endtask
  // A clock with select high rearms the frame counter.
  task automatic gap();
    tick(1'b1, ~din);
  endtask
  // Chip select for the parallel port.
  task automatic cs(input logic s);
    #8 sync_n = s;
  endtask
  // Write frame of n bits taken from the top of w, top bit first.
  task automatic write_bits(input logic [23:0] w, input int n);
    gap();
    for (int i = 23; i > 23 - n; i--) begin
      tick(1'b0, w[i]);
    end
    #8 sync_n = 1'b1;
    din = ~din;
  endtask
  // Ten-bit command write.
  task automatic write_cmd(input logic [9:0] w);
    write_bits({w, 14'h0000}, 10);
  endtask
  // Readback frame: each bit is taken just before its falling edge.
  task automatic read_bits(output logic [13:0] w, output logic bad);
    gap();
    bad = ~sdo_oe_n;
    for (int i = 13; i >= 0; i--) begin
      #8 sync_n = 1'b0;
      din = ~din;
      #24 sclk = 1'b1;
      // A released line reads as the inverse of the last driven bit.
      #30 w[i] = sdo_oe_n ? ~sdo_o : sdo_o;
      bad = bad | sdo_oe_n;
      #2 sclk = 1'b0;
    end
    #8 bad = bad | ~sdo_oe_n;
    sync_n = 1'b1;
  endtask
endmodule

// ==== bench/test_sample_hold_channel_control.sv ====
// Self-checking bench of the sample-and-hold channel control block.
// Assumes the host model drives the serial pins and shares frame select.
`timescale 1ns/1ps
module test_sample_hold_channel_control;
  logic clk, reset, port_select, track_reset_n, wr_n;
  logic par_offset_sel, par_all_chan, sclk, sync_n, din;
  logic sdo_o, sdo_oe_n, busy_n, bad;
  logic [4:0] channel_address;
  logic [13:0] conv_code, word;
  logic [32:0] follow_input;
  logic [31:0][13:0] readback_code;
  logic [13:0] offset_channel_output;
  int err_total, total_checks;
  // Device under test with a short all-channel acquisition.
  shc_top #(.ALL_ACQ_CYCLES(40)) dut (.clk(clk), .reset(reset),
    .port_select(port_select), .track_reset_n(track_reset_n),
    .sclk(sclk), .sync_n(sync_n), .din(din), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n), .wr_n(wr_n), .channel_address(channel_address),
    .par_offset_sel(par_offset_sel), .par_all_chan(par_all_chan),
    .conv_code(conv_code), .busy_n(busy_n), .follow_input(follow_input),
    .readback_code(readback_code),
    .offset_channel_output(offset_channel_output));
  // Host at the serial side.
  shc_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
  // System clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits n system clocks, sampling just after the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Builds a command word; the test bit is always zero.
  function automatic logic [9:0] cmd(input logic [1:0] m, input logic a,
                                     input logic o, input logic [4:0] ad);
    return {m, a, o, 1'b0, ad};
  endfunction
  // Gives the link side clocks so resets and strap changes reach it.
  task automatic flush();
    repeat (8) host.gap();
  endtask
  // Waits for an acquisition, measures it and checks the buffer source.
  task automatic acq(input int ch, input int len);
    int n;
    n = 0;
    while (busy_n !== 1'b0) begin
      cyc(1);
      n++;
      if (n > 40) begin
        chk({31'h0, busy_n}, 32'h0);
        report_and_stop();
      end
    end
    chk({31'h0, follow_input[ch]}, 32'h1);
    n = 0;
    while (busy_n === 1'b0 && n < 6000) begin
      cyc(1);
      n++;
    end
    chk(n, len);
    if (n >= 6000) begin
      report_and_stop();
    end
    chk({31'h0, follow_input[ch]}, 32'h0);
  endtask
  // Power-on state of outputs and stored codes.
  task automatic t_reset_vals();
    chk({31'h0, readback_code === '0}, 32'h1);
    chk({18'h0, offset_channel_output}, 32'h0);
    chk({30'h0, busy_n, sdo_oe_n}, 32'h3);
    chk(follow_input[31:0], 32'h0);
  endtask
  // Hold-acquire write to channel 19 with defer high.
  task automatic t_hold();
    @(posedge clk) conv_code <= 14'h1a5c;
    host.write_cmd(cmd(shc_pkg::SHC_MODE_HOLD, 1'b0, 1'b0, 5'h13));
    acq(19, 1600);
    chk({18'h0, readback_code[19]}, 32'h1a5c);
    chk({18'h0, readback_code[18]}, 32'h0);
  endtask
  // Readback-only of channel 19: no acquisition, stored code shifted out.
  task automatic t_readback();
    host.write_cmd(cmd(shc_pkg::SHC_MODE_RB, 1'b0, 1'b0, 5'h13));
    cyc(50);
    chk({31'h0, busy_n}, 32'h1);
    host.read_bits(word, bad);
    chk({18'h0, word}, 32'h1a5c);
    chk({31'h0, bad}, 32'h0);
  endtask
  // Acquire then readback on channel 4.
  task automatic t_acq_rb();
    @(posedge clk) conv_code <= 14'h2b71;
    host.write_cmd(cmd(shc_pkg::SHC_MODE_ACQ_RB, 1'b0, 1'b0, 5'h04));
    acq(4, 1600);
    cyc(50);
    host.read_bits(word, bad);
    chk({18'h0, word}, 32'h2b71);
    chk({31'h0, bad}, 32'h0);
  endtask
  // Offset select wins over the address; all-channel takes all 32 channels.
  task automatic t_offset_all();
    @(posedge clk) conv_code <= 14'h0ff0;
    host.write_cmd(cmd(shc_pkg::SHC_MODE_HOLD, 1'b0, 1'b1, 5'h04));
    acq(32, 1600);
    chk({18'h0, offset_channel_output}, 32'h0ff0);
    chk({18'h0, readback_code[4]}, 32'h2b71);
    @(posedge clk) conv_code <= 14'h3333;
    host.write_cmd(cmd(shc_pkg::SHC_MODE_HOLD, 1'b1, 1'b0, 5'h00));
    acq(0, 40);
    chk({readback_code[0], 4'h0, readback_code[31]}, 32'hcccc3333);
  endtask
  // A select rise in mid-frame is ignored and the word still lands.
  task automatic t_frame_edges();
    logic [9:0] w;
    w = cmd(shc_pkg::SHC_MODE_HOLD, 1'b0, 1'b0, 5'h06);
    @(posedge clk) conv_code <= 14'h0246;
    host.gap();
    for (int i = 9; i >= 0; i--) begin
      host.tick(i == 5, w[i]);
    end
    host.cs(1'b1);
    acq(6, 1600);
    chk({18'h0, readback_code[6]}, 32'h0246);
  endtask
  // Mode 01 locks out commands until a 24-clock write.
  task automatic t_test();
    host.write_cmd(cmd(shc_pkg::SHC_MODE_TEST, 1'b0, 1'b0, 5'h02));
    cyc(50);
    chk({31'h0, busy_n}, 32'h1);
    host.write_bits(24'h5a5a5a, 24);
    @(posedge clk) conv_code <= 14'h0abc;
    host.write_cmd(cmd(shc_pkg::SHC_MODE_HOLD, 1'b0, 1'b0, 5'h02));
    acq(2, 1600);
    chk({18'h0, readback_code[2]}, 32'h0abc);
  endtask
  // Parallel write strobe with the given pins.
  task automatic strobe(input logic [4:0] a, input logic off);
    @(posedge clk) channel_address <= a;
    par_offset_sel <= off;
    cyc(4);
    @(posedge clk) wr_n <= 1'b0;
    cyc(4);
    @(posedge clk) wr_n <= 1'b1;
  endtask
  // Parallel port: serial ignored, deferred write, then offset pin.
  task automatic t_parallel();
    @(posedge clk) port_select <= 1'b0;
    flush();
    host.write_cmd(cmd(shc_pkg::SHC_MODE_HOLD, 1'b0, 1'b0, 5'h01));
    cyc(50);
    chk({31'h0, busy_n}, 32'h1);
    @(posedge clk) track_reset_n <= 1'b0;
    conv_code <= 14'h1234;
    cyc(30);
    host.cs(1'b0);
    strobe(5'h09, 1'b0);
    cyc(10);
    chk({follow_input[9], busy_n}, 32'h3);
    @(posedge clk) track_reset_n <= 1'b1;
    acq(9, 1600);
    chk({18'h0, readback_code[9]}, 32'h1234);
    @(posedge clk) conv_code <= 14'h0777;
    strobe(5'h09, 1'b1);
    acq(32, 1600);
    chk({readback_code[9], 4'h0, offset_channel_output},
        32'h48d00777);
    // The all-channel pin wins over offset select, offset kept.
    @(posedge clk) conv_code <= 14'h0555;
    par_all_chan <= 1'b1;
    strobe(5'h09, 1'b1);
    acq(0, 40);
    chk({readback_code[31], 4'h0, offset_channel_output},
        32'h15540777);
    @(posedge clk) par_offset_sel <= 1'b0;
    par_all_chan <= 1'b0;
    port_select <= 1'b1;
    host.cs(1'b1);
    flush();
  endtask
  // Short low pulse is a glitch; a 13-cycle pulse resets all codes.
  task automatic t_soft_reset();
    @(posedge clk) track_reset_n <= 1'b0;
    cyc(5);
    @(posedge clk) track_reset_n <= 1'b1;
    cyc(20);
    chk({18'h0, readback_code[19]}, 32'h0555);
    @(posedge clk) track_reset_n <= 1'b0;
    cyc(12);
    @(posedge clk) track_reset_n <= 1'b1;
    cyc(20);
    chk({31'h0, readback_code === '0}, 32'h1);
    chk({18'h0, offset_channel_output}, 32'h0);
    flush();
  endtask
  // Main sequence.
  initial begin
    err_total = 0;
    total_checks = 0;
    reset = 1'b1;
    port_select = 1'b1;
    track_reset_n = 1'b1;
    wr_n = 1'b1;
    channel_address = 5'h00;
    par_offset_sel = 1'b0;
    par_all_chan = 1'b0;
    conv_code = 14'h0000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    flush();
    t_reset_vals();
    t_hold();
    t_readback();
    t_acq_rb();
    t_offset_all();
    t_frame_edges();
    t_test();
    t_parallel();
    t_soft_reset();
    report_and_stop();
  end
endmodule
